// ---- shared/sram_port_pkg.sv ----
// Constants and types shared by the synchronous burst SRAM port
package sram_port_pkg;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int ADDR_W_DEF = 19;
	localparam int ADDR_W_MIN = 3;
	localparam int ADDR_W_MAX = 20;
	localparam int SYNC_STAGES = 2;
	localparam int STEP_W = 2;
	localparam logic [STEP_W-1:0] STEP_RST = 2'h0;
	localparam logic [STEP_W-1:0] STEP_ONE = 2'h1;
	localparam logic FIRST_RST = 1'b0;
	localparam logic OE_N_RST = 1'b1;
	localparam logic TDO_RST = 1'b0;

	typedef enum logic [2:0] {
		ST_DESEL = 3'h1,
		ST_ACTIVE = 3'h2,
		ST_SLEEP = 3'h4
	} port_state_type;

	// One byte lane with its parity bit
	typedef struct packed {
		logic parity;
		logic [LANE_W-1:0] data;
	} lane_type;

	typedef lane_type [LANES-1:0] word_type;

	// Asynchronous pins carried through the synchroniser together
	typedef struct packed {
		logic out_enable_n;
		logic sleep;
		logic burst_order;
		logic tck;
		logic tdi;
	} async_pins_type;

	localparam int ASYNC_W = $bits(async_pins_type);
endpackage

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for asynchronous pins
`timescale 1ns/1ns
module pin_sync
	import sram_port_pkg::*;
#(
	parameter int W = ASYNC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] dout_r;
	logic [W-1:0] dout_nxt;

	generate
		if (W < 1) begin : g_bad_width
			$error("pin_sync width must be at least one");
		end
	endgenerate

	// The first stage feeds only the second
	always_comb begin
		meta_nxt = din;
		dout_nxt = meta_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			dout_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			dout_r <= dout_nxt;
		end
	end

	assign dout = dout_r;
endmodule // pin_sync

// ---- hw/sync_burst_sram.sv ----
// Pipelined synchronous burst SRAM port with its storage array
//
// Function
// - Capture address only on a strobe with all chip enables active.
// - Low two address bits seed the two-bit burst counter.
// - Each active-low lane select writes its lane only with lane qualify.
// - All-bytes write low writes every lane, ignoring selects and qualify.
// - Burst counter steps on each edge of a burst with burst step low and no strobe acting.
// - Selected only when primary, tertiary low and secondary high.
// - Processor strobe ignored while primary enable is high.
// - Data and parity driven while output enable low, else released.
// - First read clock after deselect keeps outputs released.
// - Strobe captures full address and loads low bits into counter.
// - Both strobes low with primary enable low: only the processor strobe acts.
// - Order strap low gives linear, high gives interleaved; held static.
// - Sleep input halts accesses while stored contents stay intact.
// - Write data registered at the edge; read data one stage later.
// - Scan input sampled on test clock rise, output on fall.
// - Outputs released whenever a write cycle is detected.
// - Processor-strobe write: controls ignored first, sampled second edge.
// - Burst counter wraps in two bits over four locations.
`timescale 1ns/1ns
module sync_burst_sram
	import sram_port_pkg::*;
#(
	parameter int ADDR_W = ADDR_W_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic cpu_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic select_primary_n,
	input wire logic select_secondary,
	input wire logic select_tertiary_n,
	input wire logic burst_step_n,
	input wire logic byte_lane0_write_select_n,
	input wire logic byte_lane1_write_select_n,
	input wire logic byte_lane2_write_select_n,
	input wire logic byte_lane3_write_select_n,
	input wire logic lane_write_qualify_n,
	input wire logic all_bytes_write_n,
	input wire logic out_enable_n,
	input wire logic burst_order,
	input wire logic sleep_request,
	input wire logic [LANES*LANE_W-1:0] data_in,
	input wire logic [LANES-1:0] parity_in,
	output logic [LANES*LANE_W-1:0] data_out,
	output logic [LANES-1:0] parity_out,
	output logic bus_oe_n,
	input wire logic tck,
	input wire logic tdi,
	output logic tdo
);
	localparam int DEPTH = 2 ** ADDR_W;

	generate
		if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX) begin : g_bad_addr
			$error("sync_burst_sram ADDR_W out of range");
		end
	endgenerate

	// Low address bits of a burst beat
	function automatic logic [STEP_W-1:0] burst_low(
		input logic [STEP_W-1:0] start,
		input logic [STEP_W-1:0] step,
		input logic interleaved
	);
		if (interleaved)
			burst_low = start ^ step;
		else
			burst_low = start + step;
	endfunction

	word_type mem [DEPTH];

	async_pins_type pins_raw;
	async_pins_type pins_s;

	port_state_type state_r, state_nxt;
	logic [ADDR_W-1:0] base_r, base_nxt;
	logic [STEP_W-1:0] step_r, step_nxt;
	logic first_r, first_nxt;
	word_type dout_r, dout_nxt;
	logic oe_n_r, oe_n_nxt;
	logic tck_d_r, tck_d_nxt;
	logic scan_r, scan_nxt;
	logic tdo_r, tdo_nxt;

	logic selected;
	logic cpu_go;
	logic ctrl_go;
	logic strobe;
	logic [LANES-1:0] lane_sel_n;
	logic [LANES-1:0] lane_we;
	logic wr_now;
	logic [ADDR_W-1:0] cur_addr;
	logic [ADDR_W-1:0] wr_addr;
	word_type wr_word;

	// Strap is synchronised too; it must not move during operation
	assign pins_raw = '{
		out_enable_n: out_enable_n,
		sleep: sleep_request,
		burst_order: burst_order,
		tck: tck,
		tdi: tdi
	};

	pin_sync #(
		.W(ASYNC_W)
	) u_pin_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(pins_raw),
		.dout(pins_s)
	);

	assign lane_sel_n = {byte_lane3_write_select_n, byte_lane2_write_select_n,
		byte_lane1_write_select_n, byte_lane0_write_select_n};

	always_comb begin
		selected = !select_primary_n && select_secondary
			&& !select_tertiary_n;
		cpu_go = !cpu_addr_strobe_n && !select_primary_n;
		ctrl_go = !ctrl_addr_strobe_n && !cpu_go;
		strobe = cpu_go || ctrl_go;
		if (!all_bytes_write_n)
			lane_we = '1;
		else if (!lane_write_qualify_n)
			lane_we = ~lane_sel_n;
		else
			lane_we = '0;
		cur_addr = {base_r[ADDR_W-1:STEP_W],
			burst_low(base_r[STEP_W-1:0], step_r, pins_s.burst_order)};
		for (int i = 0; i < LANES; i++) begin
			wr_word[i].parity = parity_in[i];
			wr_word[i].data = data_in[i*LANE_W +: LANE_W];
		end
	end

	always_comb begin
		state_nxt = state_r;
		base_nxt = base_r;
		step_nxt = step_r;
		first_nxt = first_r;
		dout_nxt = dout_r;
		oe_n_nxt = 1'b1;
		wr_now = 1'b0;
		wr_addr = cur_addr;
		if (pins_s.sleep) begin
			state_nxt = ST_SLEEP;
		end else begin
			unique case (state_r)
				ST_SLEEP: begin
					state_nxt = ST_DESEL;
				end
				ST_DESEL: begin
					if (strobe && selected) begin
						state_nxt = ST_ACTIVE;
						base_nxt = addr;
						step_nxt = STEP_RST;
						first_nxt = 1'b1;
						if (ctrl_go && (|lane_we)) begin
							wr_now = 1'b1;
							wr_addr = addr;
						end
					end
				end
				ST_ACTIVE: begin
					// Burst beat at the held address
					if (!strobe && (|lane_we)) begin
						wr_now = 1'b1;
					end else begin
						dout_nxt = mem[cur_addr];
						oe_n_nxt = pins_s.out_enable_n || first_r;
						first_nxt = 1'b0;
					end
					if (strobe && !selected) begin
						state_nxt = ST_DESEL;
						oe_n_nxt = 1'b1;
					end else if (strobe) begin
						base_nxt = addr;
						step_nxt = STEP_RST;
						// Processor strobe ignores write controls here
						if (ctrl_go && (|lane_we)) begin
							wr_now = 1'b1;
							wr_addr = addr;
							oe_n_nxt = 1'b1;
						end
					end else if (!burst_step_n) begin
						step_nxt = step_r + STEP_ONE;
					end
				end
				default: begin
					state_nxt = ST_DESEL;
				end
			endcase
		end
		if (wr_now)
			oe_n_nxt = 1'b1;
	end

	// Boundary-scan bypass path on the sampled test clock
	always_comb begin
		tck_d_nxt = pins_s.tck;
		scan_nxt = scan_r;
		tdo_nxt = tdo_r;
		if (pins_s.tck && !tck_d_r)
			scan_nxt = pins_s.tdi;
		if (!pins_s.tck && tck_d_r)
			tdo_nxt = scan_r;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_DESEL;
			base_r <= '0;
			step_r <= STEP_RST;
			first_r <= FIRST_RST;
			dout_r <= '0;
			oe_n_r <= OE_N_RST;
			tck_d_r <= 1'b0;
			scan_r <= 1'b0;
			tdo_r <= TDO_RST;
		end else begin
			state_r <= state_nxt;
			base_r <= base_nxt;
			step_r <= step_nxt;
			first_r <= first_nxt;
			dout_r <= dout_nxt;
			oe_n_r <= oe_n_nxt;
			tck_d_r <= tck_d_nxt;
			scan_r <= scan_nxt;
			tdo_r <= tdo_nxt;
		end
	end

	// Storage keeps no reset so sleep and reset leave contents intact
	always_ff @(posedge clk) begin
		if (wr_now) begin
			for (int i = 0; i < LANES; i++) begin
				if (lane_we[i])
					mem[wr_addr][i] <= wr_word[i];
			end
		end
	end

	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			data_out[i*LANE_W +: LANE_W] = dout_r[i].data;
			parity_out[i] = dout_r[i].parity;
		end
	end

	assign bus_oe_n = oe_n_r;
	assign tdo = tdo_r;
endmodule // sync_burst_sram

// ---- verification/sync_burst_sram_checker.sv ----
// Pin-level assertions for the burst SRAM port
`timescale 1ns/1ns
module sync_burst_sram_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_addr_strobe_n,
	input wire logic ctrl_addr_strobe_n,
	input wire logic select_primary_n,
	input wire logic select_secondary,
	input wire logic select_tertiary_n,
	input wire logic lane_write_qualify_n,
	input wire logic byte_lane0_write_select_n,
	input wire logic all_bytes_write_n,
	input wire logic out_enable_n,
	input wire logic sleep_request,
	input wire logic bus_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire sel = !select_primary_n && select_secondary && !select_tertiary_n;
	wire cs = !ctrl_addr_strobe_n && cpu_addr_strobe_n;
	wire cp = !cpu_addr_strobe_n && !select_primary_n;
	wire quiet = cpu_addr_strobe_n && ctrl_addr_strobe_n;
	a_desel_release:
		assert property (cs && !select_secondary |=> bus_oe_n)
		else $error("deselect left pins driven");
	a_enable_combo:
		assert property (cs && select_tertiary_n |=> bus_oe_n)
		else $error("tertiary high still selected");
	a_write_release:
		assert property (cs && sel && !all_bytes_write_n |=> bus_oe_n)
		else $error("pins driven during write");
	a_lane_release:
		assert property (cs && sel && !lane_write_qualify_n
			&& !byte_lane0_write_select_n |=> bus_oe_n)
		else $error("pins driven during lane write");
	a_oe_release:
		assert property (out_enable_n [*4] |=> bus_oe_n)
		else $error("pins driven with enable high");
	a_first_masked:
		assert property (cs && !sel ##1 cp && sel |=> ##1 bus_oe_n)
		else $error("first beat not masked");
	a_sleep_quiet:
		assert property (sleep_request [*4] |=> bus_oe_n)
		else $error("pins driven in sleep");
	a_cpu_write:
		assert property (cp && sel ##1 quiet && !all_bytes_write_n
			|=> bus_oe_n)
		else $error("pins driven on second write edge");
endmodule // sync_burst_sram_checker

// ---- verification/sram_pin_model.sv ----
// Controller side of the shared data and parity pins
`timescale 1ns/1ns
module sram_pin_model (
	input wire logic clk,
	input wire logic drive,
	input wire logic [35:0] val,
	input wire logic [31:0] data_out,
	input wire logic [3:0] parity_out,
	input wire logic bus_oe_n,
	output logic [31:0] data_in,
	output logic [3:0] parity_in
);
	logic [35:0] last_r = '0;
	logic [35:0] pin;
	// Floating pins toggle so stale data never reads as valid
	always_comb begin
		if (drive)
			pin = val;
		else if (!bus_oe_n)
			pin = {parity_out, data_out};
		else
			pin = ~last_r;
	end
	always_ff @(posedge clk)
		last_r <= pin;
	assign {parity_in, data_in} = pin;
endmodule // sram_pin_model

// ---- verification/tb.sv ----
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ns
module tb;
	localparam int AW = 6;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [AW-1:0] addr = '0;
	logic cpu_addr_strobe_n = 1'h1;
	logic ctrl_addr_strobe_n = 1'h1;
	logic select_primary_n = 1'h0;
	logic select_secondary = 1'h1;
	logic select_tertiary_n = 1'h0;
	logic burst_step_n = 1'h1;
	logic [3:0] bsel_n = 4'hF;
	logic lane_write_qualify_n = 1'h1;
	logic all_bytes_write_n = 1'h1;
	logic out_enable_n = 1'h1;
	logic burst_order = 1'h0;
	logic sleep_request = 1'h0;
	logic tck = 1'h0;
	logic tdi = 1'h0;
	logic drive = 1'h0;
	logic [35:0] val = '0;
	logic [31:0] data_in;
	logic [31:0] data_out;
	logic [3:0] parity_in;
	logic [3:0] parity_out;
	logic bus_oe_n;
	logic tdo;
	logic [35:0] exp_mem [64];
	int failures = 0;
	int samples_checked = 0;
	sync_burst_sram #(.ADDR_W(AW)) dut (.*,
		.byte_lane0_write_select_n(bsel_n[0]),
		.byte_lane1_write_select_n(bsel_n[1]),
		.byte_lane2_write_select_n(bsel_n[2]),
		.byte_lane3_write_select_n(bsel_n[3]));
	sram_pin_model pins (.*);
	always #5 clk = ~clk;
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("failures %0d samples_checked %0d", failures,
			samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic idle();
		{cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n} = 3'h7;
		{lane_write_qualify_n, all_bytes_write_n, drive} = 3'h6;
		bsel_n = 4'hF;
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [35:0] d,
		input logic [3:0] s, input logic q, input logic g);
		@(negedge clk);
		{ctrl_addr_strobe_n, addr, drive, val} = {1'h0, a, 1'h1, d};
		{bsel_n, lane_write_qualify_n, all_bytes_write_n} = {s, q, g};
		note_wr(a, d, s, q, g);
		@(negedge clk);
		idle();
	endtask
	// Expected contents after a write with the given controls
	task automatic note_wr(input logic [AW-1:0] a, input logic [35:0] d,
		input logic [3:0] s, input logic q, input logic g);
		for (int l = 0; l < 4; l++)
			if (!g || (!q && !s[l])) begin
				exp_mem[a][32+l] = d[32+l];
				exp_mem[a][8*l +: 8] = d[8*l +: 8];
			end
	endtask
	// Both strobes with global write at the strobe edge: nothing written
	// there, so a controller strobe taken by mistake would clobber lanes
	task automatic cpu_wr(input logic [AW-1:0] a, input logic [3:0] s,
		input logic q, input logic g);
		@(negedge clk);
		{cpu_addr_strobe_n, ctrl_addr_strobe_n, addr} = {2'h0, a};
		{all_bytes_write_n, drive, val} = {2'h1, 36'h0};
		@(negedge clk);
		{cpu_addr_strobe_n, ctrl_addr_strobe_n} = 2'h3;
		{bsel_n, lane_write_qualify_n, all_bytes_write_n} = {s, q, g};
		val = 36'hF12345678;
		note_wr(a, val, s, q, g);
		@(negedge clk);
		idle();
	endtask
	task automatic desel();
		@(negedge clk);
		{ctrl_addr_strobe_n, select_secondary} = 2'h0;
		@(negedge clk);
		{ctrl_addr_strobe_n, select_secondary} = 2'h3;
		chk(bus_oe_n, 1);
	endtask
	// Every read starts from deselect, so beat one is always masked
	task automatic rd(input logic [AW-1:0] a, input int n);
		logic [1:0] b;
		desel();
		{cpu_addr_strobe_n, addr} = {1'h0, a};
		@(negedge clk);
		{cpu_addr_strobe_n, burst_step_n} = 2'h2;
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			b = burst_order ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
			chk({parity_out, data_out}, exp_mem[{a[AW-1:2], b}]);
			chk(bus_oe_n, i == 0);
		end
		burst_step_n = 1'h1;
	endtask
	// Ignored strobe, held step and tertiary deselect inside one burst
	task automatic gate();
		desel();
		{cpu_addr_strobe_n, addr} = {1'h0, 6'h4};
		@(negedge clk);
		cpu_addr_strobe_n = 1'h1;
		@(negedge clk);
		chk(bus_oe_n, 1);
		{cpu_addr_strobe_n, select_primary_n} = 2'h1;
		@(negedge clk);
		{cpu_addr_strobe_n, select_primary_n} = 2'h2;
		chk({parity_out, data_out}, exp_mem[4]);
		chk(bus_oe_n, 0);
		{ctrl_addr_strobe_n, select_tertiary_n} = 2'h1;
		@(negedge clk);
		{ctrl_addr_strobe_n, select_tertiary_n} = 2'h2;
		chk(bus_oe_n, 1);
	endtask
	// Sleep must swallow a write and keep the stored word
	task automatic sleep_test();
		logic [35:0] keep;
		keep = exp_mem[1];
		sleep_request = 1'h1;
		repeat (8) @(negedge clk);
		wr(6'h1, 36'h0, 4'hF, 1'h1, 1'h0);
		exp_mem[1] = keep;
		sleep_request = 1'h0;
		repeat (5) @(negedge clk);
		rd(6'h1, 1);
	endtask
	task automatic scan_test();
		for (int b = 1; b >= 0; b--) begin
			tdi = 1'(b);
			repeat (3) @(negedge clk);
			tck = 1'h1;
			repeat (4) @(negedge clk);
			tck = 1'h0;
			repeat (5) @(negedge clk);
			chk(tdo, b);
		end
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst_n = 1'h1;
		for (int i = 0; i < 8; i++)
			wr(AW'(i), {4'(i), {8{4'(i + 8)}}}, 4'hF, 1'h1, 1'h0);
		wr(6'h5, 36'h0, 4'hA, 1'h0, 1'h1);
		wr(6'h6, 36'h0, 4'h0, 1'h1, 1'h1);
		cpu_wr(6'h7, 4'hF, 1'h1, 1'h0);
		cpu_wr(6'h6, 4'hE, 1'h0, 1'h1);
		out_enable_n = 1'h0;
		for (int m = 0; m < 2; m++) begin
			rst_n = 1'h0;
			burst_order = 1'(m);
			repeat (3) @(negedge clk);
			rst_n = 1'h1;
			repeat (3) @(negedge clk);
			for (int a = 0; a < 8; a++)
				rd(AW'(a), 4);
		end
		gate();
		sleep_test();
		scan_test();
		finish_test();
	end
endmodule // tb
bind sync_burst_sram sync_burst_sram_checker ac (.*);
